// File: hfte_pkg.sv
// Constants, register map and types for the hardware frame trigger block.
// Assumes a single 25 MHz clock and APB register access.
package hfte_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned US_CYCLES = CLK_HZ / US_PER_S;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_EXPOSURE = 12'h004;
  localparam logic [11:0] ADDR_DELAY = 12'h008;
  localparam logic [11:0] ADDR_SWTRIG = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_MASK = 12'h014;
  localparam logic [11:0] ADDR_STATE = 12'h018;

  localparam logic [1:0] SRC_LINE1 = 2'h0;
  localparam logic [1:0] SRC_LINE2 = 2'h1;
  localparam logic [1:0] SRC_SOFTWARE = 2'h2;

  localparam int unsigned EV_OVERTRIG = 0;
  localparam int unsigned EV_FRAME_START = 1;
  localparam int unsigned EV_EXPOSE_END = 2;
  localparam int unsigned EV_W = 3;

  localparam logic [19:0] EXPOSURE_RST = 20'h00BB8;
  localparam logic [19:0] DELAY_RST = 20'h00000;

  typedef struct packed {
    logic width_mode;
    logic [1:0] source;
    logic falling;
    logic enable;
  } hfte_ctrl_t;

  localparam hfte_ctrl_t CTRL_RST = '{width_mode: 1'b0, source: SRC_LINE1, falling: 1'b0,
                                      enable: 1'b0};

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DELAY, ST_EXPOSE} hfte_state_t;

endpackage

// File: hfte_trigger.sv
// Hardware frame start trigger with exposure control and trigger delay.
// Assumes trigger lines are asynchronous pins; registers reached over APB.
`timescale 1ns/1ps
`default_nettype none

module hfte_trigger #(
  parameter int unsigned NUM_LINES = 2,
  parameter int unsigned CNT_W = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_LINES-1:0] external_frame_trigger_input,
  output logic frame_start,
  output logic exposure_active,
  output logic trigger_ready,
  output logic overtrigger,
  output logic irq
);

  // Two-stage synchronisers, one per line
  logic [NUM_LINES-1:0] sync1;
  logic [NUM_LINES-1:0] sync2;
  logic [NUM_LINES-1:0] line_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          line_q[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= external_frame_trigger_input[gi];
          sync2[gi] <= sync1[gi];
          line_q[gi] <= sync2[gi];
        end
      end
    end
  endgenerate

  // Registers
  hfte_pkg::hfte_ctrl_t ctrl;
  logic [CNT_W-1:0] exposure_us;
  logic [CNT_W-1:0] delay_us;
  logic [hfte_pkg::EV_W-1:0] status;
  logic [hfte_pkg::EV_W-1:0] mask;
  logic sw_trig;

  hfte_pkg::hfte_state_t state;
  hfte_pkg::hfte_state_t next_state;
  logic [CNT_W-1:0] us_cnt;
  logic [4:0] div_cnt;
  logic us_tick;

  // APB decode; one wait state so read data comes from a flop
  wire access = psel & penable & ~pready;
  wire wr_en = psel & penable & pready & pwrite;
  wire hit_ctrl = paddr == hfte_pkg::ADDR_CTRL;
  wire hit_exp = paddr == hfte_pkg::ADDR_EXPOSURE;
  wire hit_dly = paddr == hfte_pkg::ADDR_DELAY;
  wire hit_sw = paddr == hfte_pkg::ADDR_SWTRIG;
  wire hit_sts = paddr == hfte_pkg::ADDR_STATUS;
  wire hit_mask = paddr == hfte_pkg::ADDR_MASK;
  wire hit_state = paddr == hfte_pkg::ADDR_STATE;
  wire hit_any = hit_ctrl | hit_exp | hit_dly | hit_sw | hit_sts | hit_mask | hit_state;

  wire [31:0] rd_ctrl = {27'h0000000, ctrl};
  wire [31:0] rd_exp = {{(32-CNT_W){1'b0}}, exposure_us};
  wire [31:0] rd_dly = {{(32-CNT_W){1'b0}}, delay_us};
  wire [31:0] rd_sts = {{(32-hfte_pkg::EV_W){1'b0}}, status};
  wire [31:0] rd_mask = {{(32-hfte_pkg::EV_W){1'b0}}, mask};
  wire st_idle = state == hfte_pkg::ST_IDLE;
  wire st_wait = state == hfte_pkg::ST_WAIT;
  wire st_delay = state == hfte_pkg::ST_DELAY;
  wire st_expose = state == hfte_pkg::ST_EXPOSE;
  wire [31:0] rd_state = {26'h0000000, sync2[0], trigger_ready, st_expose, st_delay, st_wait,
                          st_idle};
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                       hit_exp ? rd_exp :
                       hit_dly ? rd_dly :
                       hit_sts ? rd_sts :
                       hit_mask ? rd_mask :
                       hit_state ? rd_state : 32'h00000000;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pready <= 1'b0;
    else
      pready <= access;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      prdata <= 32'h00000000;
    else
      prdata <= (access && !pwrite) ? rd_mux : 32'h00000000;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pslverr <= 1'b0;
    else
      pslverr <= access & ~hit_any;
  end

  wire wr_ctrl = wr_en & hit_ctrl;
  wire wr_exp = wr_en & hit_exp;
  wire wr_dly = wr_en & hit_dly;
  wire wr_mask = wr_en & hit_mask;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ctrl <= hfte_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl <= pwdata[4:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      exposure_us <= CNT_W'(hfte_pkg::EXPOSURE_RST);
    else if (wr_exp)
      exposure_us <= pwdata[CNT_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      delay_us <= CNT_W'(hfte_pkg::DELAY_RST);
    else if (wr_dly)
      delay_us <= pwdata[CNT_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      mask <= '0;
    else if (wr_mask)
      mask <= pwdata[hfte_pkg::EV_W-1:0];
  end

  // Software trigger is a one-cycle strobe from a write of one
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      sw_trig <= 1'b0;
    else
      sw_trig <= wr_en & hit_sw & pwdata[0];
  end

  // Trigger source and edge selection
  wire src_sw = ctrl.source == hfte_pkg::SRC_SOFTWARE;
  wire src_l2 = ctrl.source == hfte_pkg::SRC_LINE2;
  wire src_line = ctrl.source == hfte_pkg::SRC_LINE1 || src_l2;
  wire lvl_now = src_l2 ? sync2[1] : sync2[0];
  wire lvl_old = src_l2 ? line_q[1] : line_q[0];
  // Active level is high for rising, low for falling
  wire lvl_active = lvl_now ^ ctrl.falling;
  wire hw_edge = src_line & (lvl_active & ~(lvl_old ^ ctrl.falling));
  wire trig_evt = ctrl.enable & (src_sw ? sw_trig : hw_edge);
  // Software triggering always runs timed
  wire width_eff = ctrl.width_mode & src_line;
  wire use_delay = src_line & (delay_us != '0);

  // Microsecond tick, restarted at each state change for exact timing
  wire restart = next_state != state;
  assign us_tick = div_cnt == 5'(hfte_pkg::US_CYCLES - 1);

  always_ff @(posedge clk)
  begin
    if (!rst_b || restart || us_tick)
      div_cnt <= 5'h00;
    else
      div_cnt <= div_cnt + 5'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || restart)
      us_cnt <= '0;
    else if (us_tick)
      us_cnt <= us_cnt + CNT_W'(1);
  end

  wire dly_done = us_cnt >= delay_us;
  // Programmed duration, at least one microsecond
  wire exp_elapsed = (us_cnt >= exposure_us) && (us_cnt != '0);
  wire exp_done = width_eff ? ~lvl_active : exp_elapsed;

  always_comb
  begin
    next_state = state;
    case (state)
      hfte_pkg::ST_IDLE:
        if (ctrl.enable)
          next_state = hfte_pkg::ST_WAIT;
      hfte_pkg::ST_WAIT:
        if (!ctrl.enable)
          next_state = hfte_pkg::ST_IDLE;
        else if (trig_evt)
          next_state = use_delay ? hfte_pkg::ST_DELAY : hfte_pkg::ST_EXPOSE;
      hfte_pkg::ST_DELAY:
        if (!ctrl.enable)
          next_state = hfte_pkg::ST_IDLE;
        else if (dly_done)
          next_state = hfte_pkg::ST_EXPOSE;
      hfte_pkg::ST_EXPOSE:
        if (!ctrl.enable)
          next_state = hfte_pkg::ST_IDLE;
        else if (exp_done)
          next_state = hfte_pkg::ST_WAIT;
      default:
        next_state = hfte_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      state <= hfte_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // Edges outside the waiting state are dropped; only timed exposure reports it
  wire in_expose = state == hfte_pkg::ST_EXPOSE;
  wire ev_over = trig_evt & in_expose & ~width_eff & ~exp_done;
  wire ev_start = next_state == hfte_pkg::ST_EXPOSE && !in_expose;
  wire ev_end = in_expose && next_state != hfte_pkg::ST_EXPOSE;
  wire [hfte_pkg::EV_W-1:0] events = {ev_end, ev_start, ev_over};
  wire [hfte_pkg::EV_W-1:0] clr = (wr_en & hit_sts) ? pwdata[hfte_pkg::EV_W-1:0] : '0;
  // Set wins over a simultaneous clear
  wire [hfte_pkg::EV_W-1:0] next_status = (status & ~clr) | events;

  // Width mode: ready follows the programmed duration, not the line
  wire next_ready = (next_state == hfte_pkg::ST_WAIT) ||
                    (in_expose && width_eff && exp_elapsed);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      status <= '0;
    else
      status <= next_status;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(next_status & mask);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      frame_start <= 1'b0;
    else
      frame_start <= ev_start;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      exposure_active <= 1'b0;
    else
      exposure_active <= next_state == hfte_pkg::ST_EXPOSE;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      trigger_ready <= 1'b0;
    else
      trigger_ready <= next_ready;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      overtrigger <= 1'b0;
    else
      overtrigger <= ev_over;
  end

endmodule

`default_nettype wire

// File: hfte_sva.sv
// Checker on the trigger outputs of the frame trigger block.
// Assumes bind to hfte_trigger; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module hfte_sva #(
  parameter int unsigned NUM_LINES = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [NUM_LINES-1:0] external_frame_trigger_input,
  input wire logic frame_start,
  input wire logic exposure_active,
  input wire logic trigger_ready,
  input wire logic overtrigger
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  start_expo_a: assert property (frame_start |-> exposure_active && !trigger_ready)
    else $error("start without exposure");
  expo_cause_a: assert property ($rose(exposure_active) |-> frame_start)
    else $error("exposure without start");
  one_start_a: assert property (frame_start |=> !frame_start)
    else $error("start held");
  start_wait_a: assert property (frame_start |-> !$past(exposure_active))
    else $error("start while busy");
  ovt_busy_a: assert property (overtrigger |-> $past(exposure_active) && !frame_start)
    else $error("bad overtrigger");
  ovt_pulse_a: assert property (overtrigger |=> !overtrigger)
    else $error("overtrigger held");
  end_ready_a: assert property ($fell(exposure_active) |-> trigger_ready)
    else $error("not ready after exposure");
  sync_lat_a: assert property ($changed(external_frame_trigger_input) |=> !frame_start [*2])
    else $error("edge not synchronised");
endmodule
`default_nettype wire

// File: hfte_src.sv
// Trigger source model driving the input lines.
// Assumes the caller spaces pulses apart.
`timescale 1ns/1ps
`default_nettype none
module hfte_src (
  input wire logic clk,
  output var logic [1:0] line
);
  initial line = 2'h0;
  task automatic level(input int i, input logic v);
    @(posedge clk);
    line[i] <= v;
  endtask
  // Width is w clock cycles, chosen by the caller
  task automatic pulse(input int i, input logic act, input int w);
    level(i, act);
    repeat (w) @(posedge clk);
    line[i] <= ~act; // Rate left to caller
  endtask
endmodule
`default_nettype wire

// File: hfte_trigger_tb.sv
// Bench for the frame trigger block: APB tasks and line pulses.
// Assumes hfte_src drives the lines; checker bound below.
`timescale 1ns/1ps
`default_nettype none
module hfte_trigger_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [1:0] line;
  logic pready, pslverr, frame_start, exposure_active, trigger_ready, overtrigger, irq, e;
  int error_cnt = 0, n_compared = 0, fs_cnt = 0, ot_cnt = 0, run = 0, len = 0, cyc = 0, t;
  always #20 clk = ~clk;
  hfte_trigger dut_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .external_frame_trigger_input(line), .frame_start,
    .exposure_active, .trigger_ready, .overtrigger, .irq);
  hfte_src src_u (.clk, .line);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic end_sim(input int bad);
    error_cnt += bad;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // Pre-edge sampling keeps counts free of update races
  always @(posedge clk)
  begin
    cyc++;
    fs_cnt += (frame_start === 1'b1);
    ot_cnt += (overtrigger === 1'b1);
    len = (exposure_active !== 1'b1 && run != 0) ? run : len;
    run = (exposure_active === 1'b1) ? run + 1 : 0;
    if (cyc == 5000) end_sim(1);
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h018, 32'h1);
    rd(12'h01C, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("reset test done");
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h014, 32'h7);
    apb(1'b1, 12'h000, 32'h1);
    src_u.pulse(0, 1'b1, 10);
    repeat (25) @(posedge clk);
    src_u.pulse(0, 1'b1, 10);
    repeat (60) @(posedge clk);
    chk(fs_cnt, 1);
    chk(ot_cnt, 1);
    chk(len, 2 * hfte_pkg::US_CYCLES + 1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h014, 32'h0);
    rd(12'h010, 32'h7);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h010, 32'h7);
    rd(12'h010, 32'h0);
    rd(12'h018, 32'h12);
    $display("timed test done");
    src_u.level(1, 1'b1);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h000, 32'h17);
    t = fs_cnt;
    src_u.pulse(0, 1'b1, 10);
    repeat (30) @(posedge clk);
    src_u.level(1, 1'b0);
    wait (fs_cnt > t);
    repeat (60) @(posedge clk);
    chk({30'h0, trigger_ready, exposure_active}, 32'h3);
    src_u.level(1, 1'b1);
    repeat (30) @(posedge clk);
    chk(fs_cnt, t + 1);
    chk(len > 60 && len < 73, 32'h1);
    $display("width test done");
    apb(1'b1, 12'h000, 32'h9);
    t = fs_cnt;
    apb(1'b1, 12'h00C, 32'h1);
    repeat (8) @(posedge clk);
    chk(fs_cnt, t + 1);
    $display("software test done");
    end_sim(0);
  end
endmodule
bind hfte_trigger hfte_sva #(.NUM_LINES(NUM_LINES)) chk_u (.clk, .rst_b,
  .external_frame_trigger_input, .frame_start, .exposure_active, .trigger_ready,
  .overtrigger);
`default_nettype wire
